// ---- pkg/caf_pkg.sv ----
// Notes on behaviour
// - Four mask registers, each paired with a match register, kept in RAM.
// - Software or system reset never changes mask register contents.
// - With a filter count of at least one, all eight registers are usable.
// - Only the first N pairs take part in comparison; the rest is storage.
// - Mask bit 1 makes a match bit count; mask bit 0 ignores it.
// - Mask bits 0..10 (bit 0 most significant) cover identifier 28..18.
// - Mask bit 11 covers the substitute remote request position.
// - Mask bit 12 covers the identifier extension flag.
// - Extension mask 1 selects frame type by stored flag; 0 takes both.
// - Mask bit 31 covers the remote request bit of an extended frame.
// - Match register contents survive software and system reset.
// - Match fields: id 0..10, srr 11, ide 12, ext id 13..30, rtr 31.
// - A frame is accepted when it matches any enabled pair.
// - With no pair enabled every received frame is stored.
// - Enable bits sit in select bits 28..31; bit 31 enables pair 1.
package caf_pkg;
  localparam int unsigned NUM_PAIRS   = 4;
  localparam int unsigned FILT_COUNT  = 4;
  localparam logic [2:0]  NUM_FILT    = 3'h4;
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_MASK1   = 8'h00;
  localparam logic [7:0]  OFS_MATCH1  = 8'h04;
  localparam logic [7:0]  OFS_STRIDE  = 8'h08;
  localparam logic [7:0]  OFS_SELECT  = 8'h20;
  localparam logic [7:0]  OFS_STATUS  = 8'h24;
  // Field positions, LSB-numbered (printed bit 0 is our bit 31)
  localparam int unsigned SEL_EN_LO   = 0;
  localparam int unsigned STAT_BUSY   = 0;
  localparam logic [3:0]  SEL_RESET   = 4'h0;
  // Compare sequencing
  localparam logic [1:0]  LAST_PAIR   = 2'h3;
  typedef enum logic [1:0] {
    CAF_IDLE = 2'b00,
    CAF_READ = 2'b01,
    CAF_EVAL = 2'b10,
    CAF_DONE = 2'b11
  } caf_state_t;
endpackage

// ---- hw/caf_filter.sv ----
`timescale 1ns/10ps
module caf_filter
  import caf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Received identifier, printed order: id, srr, ide, ext id, rtr
  input  wire logic [31:0] rx_id,
  input  wire logic        rx_valid,
  // Result
  output logic             rx_done,
  output logic             rx_store,
  output logic             filter_busy_flag
);
  // Bits kept LSB-numbered: printed bit k is bit 31-k here.
  // So mask bit 0 (id 28) is [31], bit 11 srr [20], 12 ide [19], 31 rtr [0].
  logic [31:0] mask_ram [NUM_PAIRS];
  logic [31:0] match_ram [NUM_PAIRS];
  logic [3:0]  use_en_q;
  caf_state_t  state_q;
  logic [1:0]  idx_q;
  logic [31:0] id_q;
  logic [31:0] mask_rd_q;
  logic [31:0] match_rd_q;
  logic        hit_q;
  logic        any_en;
  logic        is_pair;
  logic [1:0]  pair_sel;
  logic        sel_match;
  logic        pair_hit;
  logic        type_ok;

  assign is_pair   = (reg_addr < OFS_SELECT) && (reg_addr[1:0] == 2'h0);
  assign pair_sel  = reg_addr[4:3];
  assign sel_match = reg_addr[2];
  // Any set enable bit turns filtering on, even for a pair beyond the configured count
  assign any_en    = |use_en_q;

  // RAM storage has no reset; contents persist across resets
  always_ff @(posedge clk)
  begin
    if (clk_en && reg_wr && is_pair && !sel_match)
      mask_ram[pair_sel] <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (clk_en && reg_wr && is_pair && sel_match)
      match_ram[pair_sel] <= reg_wdata;
  end

  // Enable bits; printed 31..28 = pair 1..4, i.e. our bits 0..3
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      use_en_q <= SEL_RESET;
    else if (clk_en && reg_wr && reg_addr == OFS_SELECT)
      use_en_q <= reg_wdata[SEL_EN_LO +: 4];
  end

  // Registered read, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata <= 32'h0;
      else if (is_pair && !sel_match)
        reg_rdata <= mask_ram[pair_sel];
      else if (is_pair)
        reg_rdata <= match_ram[pair_sel];
      else if (reg_addr == OFS_SELECT)
        reg_rdata <= {28'h0, use_en_q};
      else if (reg_addr == OFS_STATUS)
        reg_rdata <= {31'h0, filter_busy_flag};
      else
        reg_rdata <= 32'h0;
    end
  end

  // Masked compare of one pair, with frame-type qualifier
  always_comb
  begin
    type_ok  = !mask_rd_q[19] || (match_rd_q[19] == id_q[19]);
    // Mask 1 compares the bit, mask 0 ignores it; fields fixed by layout
    pair_hit = ((id_q & mask_rd_q) == (match_rd_q & mask_rd_q))
               && type_ok;
  end

  // One pair every two cycles; RAM read in READ, compare in EVAL
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= CAF_IDLE;
      idx_q      <= 2'h0;
      id_q       <= 32'h0;
      hit_q      <= 1'b0;
      mask_rd_q  <= 32'h0;
      match_rd_q <= 32'h0;
    end
    else if (clk_en)
    begin
      case (state_q)
        CAF_IDLE:
        begin
          if (rx_valid)
          begin
            id_q    <= rx_id;
            idx_q   <= 2'h0;
            hit_q   <= 1'b0;
            state_q <= CAF_READ;
          end
        end
        CAF_READ:
        begin
          mask_rd_q  <= mask_ram[idx_q];
          match_rd_q <= match_ram[idx_q];
          state_q    <= CAF_EVAL;
        end
        CAF_EVAL:
        begin
          if (use_en_q[idx_q] && ({1'b0, idx_q} < NUM_FILT) && pair_hit)
            hit_q <= 1'b1;
          if (idx_q == LAST_PAIR)
            state_q <= CAF_DONE;
          else
          begin
            idx_q   <= idx_q + 2'h1;
            state_q <= CAF_READ;
          end
        end
        CAF_DONE:
          state_q <= CAF_IDLE;
        default:
          state_q <= CAF_IDLE;
      endcase
    end
  end

  // Result pulse and busy flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_done          <= 1'b0;
      rx_store         <= 1'b0;
      filter_busy_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_done          <= (state_q == CAF_DONE);
      rx_store         <= (state_q == CAF_DONE) && (hit_q || !any_en);
      filter_busy_flag <= (state_q == CAF_IDLE) ? rx_valid
                          : (state_q != CAF_DONE);
    end
  end

  // Checks
  // Step sequences carry clk_en, so a frozen cycle never counts as a step
  sequence accept_s;
    clk_en && rx_valid && state_q == CAF_IDLE;
  endsequence

  sequence read_s;
    clk_en && state_q == CAF_READ;
  endsequence

  sequence eval_s;
    clk_en && state_q == CAF_EVAL && idx_q != LAST_PAIR;
  endsequence

  sequence last_s;
    clk_en && state_q == CAF_EVAL && idx_q == LAST_PAIR;
  endsequence

  sequence done_s;
    clk_en && state_q == CAF_DONE;
  endsequence

  done_pulse_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      done_s |=> rx_done)
    else $error("done pulse missing");
  store_all_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (done_s and (use_en_q == 4'h0)) |=> rx_store)
    else $error("frame not stored with no filter");
  store_only_done_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_store |-> rx_done)
    else $error("store without done");
  busy_cover_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rx_valid && state_q == CAF_IDLE |=> filter_busy_flag [*3])
    else $error("busy dropped during compare");
  walk_len_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rx_valid && state_q == CAF_IDLE |-> ##[8:300] rx_done)
    else $error("compare did not finish");
  sel_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == OFS_SELECT
      |=> reg_rdata[31:4] == 28'h0)
    else $error("select reserved bits not zero");
  no_hit_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (done_s and (!hit_q && any_en)) |=> !rx_store)
    else $error("stored without match");
  idle_rd_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without strobe");

  // Walk of one frame, built from the step sequences except done_once_a, which uses rx_done
  accept_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      accept_s |=> state_q == CAF_READ && idx_q == 2'h0 && filter_busy_flag)
    else $error("frame not taken from idle");
  read_eval_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      read_s |=> state_q == CAF_EVAL && filter_busy_flag)
    else $error("read step not followed by compare");
  first_step_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      accept_s ##1 read_s ##1 eval_s
      |=> state_q == CAF_READ && idx_q == 2'h1)
    else $error("second pair not read after first");
  pair_step_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      eval_s |=> state_q == CAF_READ && idx_q == $past(idx_q) + 2'h1)
    else $error("pair index did not advance");
  last_pair_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      read_s ##1 last_s |=> state_q == CAF_DONE && filter_busy_flag)
    else $error("last pair did not end the walk");
  done_idle_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      done_s |=> state_q == CAF_IDLE && !filter_busy_flag)
    else $error("busy held after the walk");
  done_once_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rx_done |=> !rx_done)
    else $error("done pulse longer than one cycle");
  // A frame offered while busy must not disturb the one in flight
  ignore_busy_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rx_valid && state_q != CAF_IDLE |=> id_q == $past(id_q))
    else $error("identifier replaced during compare");

  // Compare and accumulate
  hit_set_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_q == CAF_EVAL && use_en_q[idx_q] && pair_hit
      |=> hit_q)
    else $error("enabled matching pair not recorded");
  skip_pair_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_q == CAF_EVAL && !use_en_q[idx_q]
      |=> hit_q == $past(hit_q))
    else $error("disabled pair changed the result");
  type_gate_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      state_q == CAF_EVAL && mask_rd_q[19] && match_rd_q[19] != id_q[19]
      |-> !pair_hit)
    else $error("wrong frame type accepted");
  mask_zero_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      state_q == CAF_EVAL && mask_rd_q == 32'h0 |-> pair_hit)
    else $error("empty mask rejected a frame");

  // Register port: writes land, reads return the stored word
  mask_write_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && is_pair && !sel_match
      |=> mask_ram[$past(pair_sel)] == $past(reg_wdata))
    else $error("mask write lost");
  match_write_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && is_pair && sel_match
      |=> match_ram[$past(pair_sel)] == $past(reg_wdata))
    else $error("match write lost");
  mask_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && is_pair && !sel_match
      |=> reg_rdata == $past(mask_ram[pair_sel]))
    else $error("mask read wrong");
  match_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && is_pair && sel_match
      |=> reg_rdata == $past(match_ram[pair_sel]))
    else $error("match read wrong");
  en_write_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == OFS_SELECT
      |=> use_en_q == $past(reg_wdata[3:0]))
    else $error("enable write lost");
  busy_read_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == OFS_STATUS
      |=> reg_rdata == {31'h0, $past(filter_busy_flag)})
    else $error("status read wrong");
endmodule

// ---- tb/caf_rx_model.sv ----
`timescale 1ns/10ps
module caf_rx_model (
  // Filter side
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        done,
  input  wire logic        store,
  output logic      [31:0] rx_id,
  output logic             rx_valid
);
  initial
  begin
    rx_id    = 32'h0;
    rx_valid = 1'b0;
  end
  // A frame is offered once idle, or after 50 busy cycles at most, since one during busy is dropped
  // Busy is caught just after the frame is taken and again beside done
  task automatic send(input logic [31:0] id, output logic st, output bit ok,
                      output logic [1:0] bz);
    int n;
    ok = 0;
    st = 1'b0;
    bz = 2'b00;
    @(posedge clk);
    for (n = 0; n < 50 && busy !== 1'b0; n++)
      @(posedge clk);
    rx_valid <= 1'b1;
    rx_id    <= id;
    @(posedge clk);
    rx_valid <= 1'b0;
    for (n = 0; n < 30 && !ok; n++)
    begin
      @(posedge clk);
      #1;
      ok = (done === 1'b1);
      st = store;
      if (n == 0)
        bz[1] = busy;
      bz[0] = busy;
    end
    // Stale id is inverted so a late sample cannot pass by chance
    @(posedge clk);
    rx_id <= ~id;
  endtask
endmodule

// ---- tb/can_acceptance_filter_match_tb_top.sv ----
`timescale 1ns/10ps
module can_acceptance_filter_match_tb_top;
  import caf_pkg::*;
  logic        clk;
  logic        rst_n     = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rx_id, sd, v;
  logic [31:0] msk [4];
  logic [31:0] mat [4];
  logic        rx_valid, rx_done, rx_store, busy, st;
  logic [3:0]  en;
  logic [1:0]  bz;
  int          num_errors, total_checks;
  bit          ok;
  caf_filter dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_id(rx_id),
    .rx_valid(rx_valid), .rx_done(rx_done), .rx_store(rx_store),
    .filter_busy_flag(busy));
  caf_rx_model part_u (.clk(clk), .busy(busy), .done(rx_done),
    .store(rx_store), .rx_id(rx_id), .rx_valid(rx_valid));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic readback;
    for (int i = 0; i < 4; i++)
    begin
      rd(OFS_MASK1 + OFS_STRIDE * 8'(i), msk[i]);
      rd(OFS_MATCH1 + OFS_STRIDE * 8'(i), mat[i]);
    end
    rd(OFS_SELECT, {28'h0, en});
    rd(OFS_STATUS, 32'h0);
    rd(8'h40, 32'h0);
  endtask
  task automatic load(input int i, input logic [31:0] m, a);
    msk[i] = m;
    mat[i] = a;
    wr(OFS_MASK1 + OFS_STRIDE * 8'(i), m);
    wr(OFS_MATCH1 + OFS_STRIDE * 8'(i), a);
  endtask
  task automatic sel(input logic [3:0] e);
    en = e;
    wr(OFS_SELECT, {28'h0, e});
  endtask
  function automatic logic exp_store(input logic [31:0] id);
    logic hit;
    hit = (en == 4'h0);
    for (int i = 0; i < 4; i++)
      if (en[i] && i < int'(FILT_COUNT) && ((id ^ mat[i]) & msk[i]) == 32'h0)
        hit = 1'b1;
    return hit;
  endfunction
  task automatic frame(input logic [31:0] id);
    part_u.send(id, st, ok, bz);
    chk("rx_done", 32'h1, {31'h0, ok});
    chk("busy", 32'h2, {30'h0, bz});
    chk("rx_store", {31'h0, exp_store(id)}, {31'h0, st});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    num_errors++;
    final_report;
  end
  initial
  begin
    sd = 32'h976b;
    en = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      v = lfsr(sd);
      sd = lfsr(v);
      load(i, v, sd);
    end
    readback;
    frame(sd);
    // Standard-frame filter: extension fields left zero
    load(0, 32'hfff80000, 32'h5a600000);
    sel(4'h1);
    frame(32'h5a600000);
    frame(32'h5a680000);
    frame(32'h5a60abcd);
    for (int k = 0; k < 48; k++)
    begin
      sd = lfsr(sd);
      sel(4'(k));
      frame(k[0] ? sd : mat[k % 4] ^ (sd & ~msk[k % 4]));
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    en = 4'h0;
    readback;
    frame(sd);
    final_report;
  end
endmodule
